// ### core/fscd_consts.svh
// constants of the flash setting command decoder and its controller
// assumes inclusion by bare name from both ends
`ifndef FSCD_CONSTS_SVH
`define FSCD_CONSTS_SVH

// device register reset values and layout
`define FSCD_STATUS_RESET    8'h00
`define FSCD_CONFIG_RESET    8'h00
`define FSCD_WEL_BIT         1
`define FSCD_STATUS_WR_MASK  8'hFC

// controller registers, byte offsets on the bus
`define FSCD_REG_CMD         8'h00
`define FSCD_REG_DATA        8'h04
`define FSCD_REG_STAT        8'h08
`define FSCD_CMD_NWR_LSB     8
`define FSCD_CMD_RD_BIT      10
`define FSCD_STAT_BUSY_BIT   0
`define FSCD_STAT_QUAD_BIT   1
`define FSCD_STAT_RX_LSB     8

// controller timing, in clk_sys cycles
`define FSCD_SCK_HALF        4
`define FSCD_CS_GAP          12

`endif

// ### core/fscd_pkg.sv
// types shared by both ends of the flash setting link
// assumes nothing beyond a SystemVerilog compiler
package fscd_pkg;
	typedef logic [7:0] fscd_byte_t;

	typedef enum logic [7:0] {
		OP_LATCH_SET     = 8'h06,
		OP_LATCH_CLEAR   = 8'h04,
		OP_STATUS_READ   = 8'h05,
		OP_CONFIG_READ   = 8'h15,
		OP_SC_WRITE      = 8'h01,
		OP_PROTECT_SEL   = 8'h68,
		OP_QUAD_ENTRY    = 8'h35,
		OP_QUAD_EXIT     = 8'hF5,
		OP_WIDE_ENTRY    = 8'hB7,
		OP_WIDE_EXIT     = 8'hE9,
		OP_POWER_DOWN    = 8'hB9,
		OP_POWER_RELEASE = 8'hAB
	} fscd_op_t;

	typedef enum logic [2:0] {
		H_IDLE  = 3'h0,
		H_SETUP = 3'h1,
		H_SHIFT = 3'h3,
		H_HOLD  = 3'h2,
		H_GAP   = 3'h6
	} fscd_hstate_t;
endpackage

// ### core/fscd_link_if.sv
// serial link between flash controller and flash setting decoder
// four io lines resolved here from both enables, idle lines pulled high
interface fscd_link_if;
	logic       cs_n;
	logic       sck;
	logic [3:0] h_out;
	logic [3:0] h_oe;
	logic [3:0] d_out;
	logic [3:0] d_oe;
	logic [3:0] io;

	assign io = (d_oe & d_out) | (~d_oe & h_oe & h_out) | ~(d_oe | h_oe);

	modport host (output cs_n, output sck, output h_out, output h_oe, input io);
	modport dev  (input cs_n, input sck, input io, output d_out, output d_oe);
endinterface

// ### core/fscd_device.sv
// flash setting command decoder, the device end of the link
// assumes a host framing whole bytes with cs_n and a cs_n high gap
// of several clk_sys cycles between frames
//
// Operation
// - opcode 04 clears write enable latch
// - opcode 05 shifts status register out
// - opcode 15 shifts configuration register out
// - opcode 01 loads status, optional configuration byte
// - opcode 68 enables individual block protect mode
// - opcode 35 enters quad mode, single-line only
// - opcode F5 leaves quad mode, quad only
// - opcode B7 sets address width flag
// - opcode E9 clears address width flag
// - power-down opcode ignores ordinary commands afterwards
// - release opcode restores normal command acceptance
`include "fscd_consts.svh"

module fscd_device (
	// system clock and reset
	input  wire logic               clk_sys,
	input  wire logic               rst_n,
	// serial link, clocked by its own sck
	fscd_link_if.dev                link,
	// decoded state
	output fscd_pkg::fscd_byte_t    status_value,
	output fscd_pkg::fscd_byte_t    config_value,
	output logic                    write_enable_latch,
	output logic                    quad_protocol_mode,
	output logic                    address_width_flag,
	output logic                    block_protect_mode,
	output logic                    deep_power_down
);
	import fscd_pkg::*;

	// link domain state
	logic [2:0] bit_cnt_reg;
	logic       first_reg;
	fscd_byte_t rx_sh_reg;
	fscd_byte_t byte_reg;
	fscd_byte_t op_link_reg;
	logic       byte_tog_reg;
	logic       frag_reg;
	fscd_byte_t tx_reg;
	logic [2:0] out_cnt_reg;
	logic       drive_reg;

	// system domain state
	logic       cs_s1_reg;
	logic       cs_s2_reg;
	logic       cs_s3_reg;
	logic       tog_s1_reg;
	logic       tog_s2_reg;
	logic       tog_s3_reg;
	logic       frag_s1_reg;
	logic       frag_s2_reg;
	logic [1:0] cnt_reg;
	fscd_byte_t op_reg;
	fscd_byte_t d1_reg;
	fscd_byte_t d2_reg;
	fscd_byte_t status_reg;
	fscd_byte_t config_reg;
	logic       wel_reg;
	logic       quad_reg;
	logic       wide_reg;
	logic       protect_reg;
	logic       pd_reg;

	// quad_reg, status and config change only while cs_n is high,
	// so the link domain sees them stable through a whole frame
	wire [2:0]  step        = quad_reg ? 3'h4 : 3'h1;
	wire [2:0]  bit_next    = bit_cnt_reg + step;
	wire        byte_done   = (bit_next == 3'h0);
	wire [7:0]  rx_next     = quad_reg ? {rx_sh_reg[3:0], link.io}
	                                   : {rx_sh_reg[6:0], link.io[0]};

	// read selection after the opcode
	wire        rd_status   = first_reg && !pd_reg && (op_link_reg == OP_STATUS_READ);
	wire        rd_config   = first_reg && !pd_reg && (op_link_reg == OP_CONFIG_READ);
	wire        rd_go       = rd_status || rd_config;
	wire [7:0]  rd_byte     = rd_status ? status_value : config_value;
	wire [7:0]  tx_shifted  = quad_reg ? (tx_reg << 4) : (tx_reg << 1);

	// frame framing: cs_n high clears the per-frame link state, since
	// sck stands still after the last bit
	always_ff @(posedge link.sck or posedge link.cs_n) begin
		if (link.cs_n) begin
			bit_cnt_reg <= 3'h0;
			first_reg   <= 1'b0;
		end else begin
			bit_cnt_reg <= bit_next;
			if (byte_done)
				first_reg <= 1'b1;
		end
	end

	// byte capture; frag_reg outlives the frame for the alignment check
	always_ff @(posedge link.sck or negedge rst_n) begin
		if (!rst_n) begin
			rx_sh_reg    <= 8'h00;
			byte_reg     <= 8'h00;
			op_link_reg  <= 8'h00;
			byte_tog_reg <= 1'b0;
			frag_reg     <= 1'b0;
		end else begin
			rx_sh_reg <= rx_next;
			frag_reg  <= !byte_done;
			if (byte_done) begin
				byte_reg     <= rx_next;
				byte_tog_reg <= !byte_tog_reg;
				if (!first_reg)
					op_link_reg <= rx_next;
			end
		end
	end

	// read data changes on falling sck, repeating until cs_n rises
	always_ff @(negedge link.sck or posedge link.cs_n) begin
		if (link.cs_n) begin
			tx_reg      <= 8'h00;
			out_cnt_reg <= 3'h0;
			drive_reg   <= 1'b0;
		end else if (rd_go) begin
			drive_reg   <= 1'b1;
			out_cnt_reg <= out_cnt_reg + step;
			tx_reg      <= (out_cnt_reg == 3'h0) ? rd_byte : tx_shifted;
		end
	end

	assign link.d_out = quad_reg ? tx_reg[7:4] : {2'h0, tx_reg[7], 1'h0};
	assign link.d_oe  = !drive_reg ? 4'h0 : (quad_reg ? 4'hF : 4'h2);

	// crossing into clk_sys: cs_n and the byte toggle as levels
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			cs_s1_reg   <= 1'b1;
			cs_s2_reg   <= 1'b1;
			cs_s3_reg   <= 1'b1;
			tog_s1_reg  <= 1'b0;
			tog_s2_reg  <= 1'b0;
			tog_s3_reg  <= 1'b0;
			frag_s1_reg <= 1'b0;
			frag_s2_reg <= 1'b0;
		end else begin
			cs_s1_reg   <= link.cs_n;
			cs_s2_reg   <= cs_s1_reg;
			cs_s3_reg   <= cs_s2_reg;
			tog_s1_reg  <= byte_tog_reg;
			tog_s2_reg  <= tog_s1_reg;
			tog_s3_reg  <= tog_s2_reg;
			frag_s1_reg <= frag_reg;
			frag_s2_reg <= frag_s1_reg;
		end
	end

	wire frame_start = cs_s3_reg && !cs_s2_reg;
	wire frame_end   = !cs_s3_reg && cs_s2_reg;
	wire byte_evt    = tog_s2_reg ^ tog_s3_reg;

	// byte_reg is quiet for at least two sck periods after its toggle
	always_ff @(posedge clk_sys) begin
		if (!rst_n || frame_start) begin
			cnt_reg <= 2'h0;
			op_reg  <= 8'h00;
			d1_reg  <= 8'h00;
			d2_reg  <= 8'h00;
		end else if (byte_evt && cnt_reg != 2'h3) begin
			cnt_reg <= cnt_reg + 2'h1;
			if (cnt_reg == 2'h0)
				op_reg <= byte_reg;
			if (cnt_reg == 2'h1)
				d1_reg <= byte_reg;
			if (cnt_reg == 2'h2)
				d2_reg <= byte_reg;
		end
	end

	// decode at frame end; extra bytes past two data bytes are dropped
	wire exec      = frame_end && !frag_s2_reg;
	wire solo      = exec && (cnt_reg == 2'h1);
	wire awake     = !pd_reg;
	wire do_set    = solo && awake && (op_reg == OP_LATCH_SET);
	wire do_clear  = solo && awake && (op_reg == OP_LATCH_CLEAR);
	wire do_write  = exec && awake && wel_reg && (op_reg == OP_SC_WRITE)
	                 && (cnt_reg >= 2'h2);
	wire do_prot   = solo && awake && (op_reg == OP_PROTECT_SEL);
	wire do_qin    = solo && awake && !quad_reg && (op_reg == OP_QUAD_ENTRY);
	wire do_qout   = solo && awake && quad_reg && (op_reg == OP_QUAD_EXIT);
	wire do_win    = solo && awake && (op_reg == OP_WIDE_ENTRY);
	wire do_wout   = solo && awake && (op_reg == OP_WIDE_EXIT);
	wire do_pd     = solo && awake && (op_reg == OP_POWER_DOWN);
	wire do_rel    = solo && pd_reg && (op_reg == OP_POWER_RELEASE);

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			wel_reg <= 1'b0;
		end else if (do_set) begin
			wel_reg <= 1'b1;
		end else if (do_clear || do_write) begin
			wel_reg <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			status_reg <= `FSCD_STATUS_RESET;
			config_reg <= `FSCD_CONFIG_RESET;
		end else if (do_write) begin
			status_reg <= d1_reg & `FSCD_STATUS_WR_MASK;
			if (cnt_reg == 2'h3)
				config_reg <= d2_reg;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			quad_reg    <= 1'b0;
			wide_reg    <= 1'b0;
			protect_reg <= 1'b0;
			pd_reg      <= 1'b0;
		end else begin
			if (do_prot)
				protect_reg <= 1'b1;
			if (do_qin)
				quad_reg <= 1'b1;
			else if (do_qout)
				quad_reg <= 1'b0;
			if (do_win)
				wide_reg <= 1'b1;
			else if (do_wout)
				wide_reg <= 1'b0;
			if (do_pd)
				pd_reg <= 1'b1;
			else if (do_rel)
				pd_reg <= 1'b0;
		end
	end

	// write enable latch reads back inside the status byte
	assign status_value = (status_reg & `FSCD_STATUS_WR_MASK)
	                      | {6'h00, wel_reg, 1'h0};
	assign config_value       = config_reg;
	assign write_enable_latch = wel_reg;
	assign quad_protocol_mode = quad_reg;
	assign address_width_flag = wide_reg;
	assign block_protect_mode = protect_reg;
	assign deep_power_down    = pd_reg;
endmodule

// ### core/fscd_host.sv
// flash setting controller, the host end of the link, an AHB-Lite slave
// assumes one master, single word transfers; makes sck by dividing clk_sys
`include "fscd_consts.svh"

module fscd_host #(
	parameter int SCK_HALF = `FSCD_SCK_HALF,
	parameter int CS_GAP   = `FSCD_CS_GAP
) (
	// system clock and reset
	input  wire logic        clk_sys,
	input  wire logic        rst_n,
	// AHB-Lite slave
	input  wire logic [31:0] haddr,
	input  wire logic        hsel,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	// serial link
	fscd_link_if.host        link
);
	import fscd_pkg::*;

	function automatic logic [5:0] units(input logic [1:0] nbytes, input logic q);
		units = q ? {3'h0, nbytes, 1'h0} : {1'h0, nbytes, 3'h0};
	endfunction

	fscd_hstate_t state_reg;
	logic        wr_pend_reg;
	logic [7:0]  addr_reg;
	logic [15:0] data_reg;
	logic [31:0] hrdata_reg;
	logic [23:0] tx_reg;
	logic [7:0]  op_reg;
	logic [1:0]  nwr_reg;
	logic        rd_reg;
	logic [7:0]  rx_reg;
	logic [7:0]  rx_byte_reg;
	logic [5:0]  unit_reg;
	logic [7:0]  div_reg;
	logic        sck_reg;
	logic        cs_n_reg;
	logic        quad_reg;
	logic [3:0]  io_s1_reg;
	logic [3:0]  io_s2_reg;

	wire        ap        = hsel && hready && htrans[1];
	wire        idle      = (state_reg == H_IDLE);
	wire        launch    = wr_pend_reg && (addr_reg == `FSCD_REG_CMD) && idle;
	wire [1:0]  nwr_raw   = hwdata[`FSCD_CMD_NWR_LSB +: 2];
	wire [1:0]  nwr_in    = (nwr_raw > 2'h2) ? 2'h2 : nwr_raw;
	wire [5:0]  tx_units  = units(2'(nwr_reg + 2'h1), quad_reg);
	wire [5:0]  all_units = tx_units + (rd_reg ? units(2'h1, quad_reg) : 6'h00);
	wire        tick      = (div_reg == 8'(SCK_HALF - 1));
	wire        gap_done  = (div_reg == 8'(CS_GAP - 1));
	wire        tx_phase  = (state_reg == H_SETUP || state_reg == H_SHIFT)
	                        && (unit_reg < tx_units);
	wire        last_unit = (unit_reg + 6'h01 == all_units);
	wire [7:0]  rx_next   = quad_reg ? {rx_reg[3:0], io_s2_reg}
	                                 : {rx_reg[6:0], io_s2_reg[1]};
	wire [31:0] rd_mux    = (haddr[7:0] == `FSCD_REG_DATA) ? {16'h0000, data_reg} :
	                        (haddr[7:0] == `FSCD_REG_STAT) ?
	                        {16'h0000, rx_byte_reg, 6'h00, quad_reg, !idle} : 32'h0000_0000;

	// zero wait states; read data registered in the address phase
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			wr_pend_reg <= 1'b0;
			addr_reg    <= 8'h00;
			hrdata_reg  <= 32'h0000_0000;
			data_reg    <= 16'h0000;
		end else begin
			wr_pend_reg <= ap && hwrite;
			if (ap)
				addr_reg <= haddr[7:0];
			if (ap && !hwrite)
				hrdata_reg <= rd_mux;
			if (wr_pend_reg && addr_reg == `FSCD_REG_DATA)
				data_reg <= hwdata[15:0];
		end
	end

	// pin inputs pass two flops; the half period covers that delay
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			io_s1_reg <= 4'hF;
			io_s2_reg <= 4'hF;
		end else begin
			io_s1_reg <= link.io;
			io_s2_reg <= io_s1_reg;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n || idle)
			div_reg <= 8'h00;
		else if ((state_reg == H_GAP) ? gap_done : tick)
			div_reg <= 8'h00;
		else
			div_reg <= div_reg + 8'h01;
	end

	// frame engine: data out changes on falling sck, read data taken on rising
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			state_reg   <= H_IDLE;
			cs_n_reg    <= 1'b1;
			sck_reg     <= 1'b0;
			quad_reg    <= 1'b0;
			tx_reg      <= 24'h00_0000;
			op_reg      <= 8'h00;
			nwr_reg     <= 2'h0;
			rd_reg      <= 1'b0;
			rx_reg      <= 8'h00;
			rx_byte_reg <= 8'h00;
			unit_reg    <= 6'h00;
		end else begin
			case (state_reg)
				H_IDLE: begin
					if (launch) begin
						// first data byte must follow the opcode on the wire
						tx_reg    <= {hwdata[7:0], data_reg[7:0], data_reg[15:8]};
						op_reg    <= hwdata[7:0];
						nwr_reg   <= nwr_in;
						rd_reg    <= hwdata[`FSCD_CMD_RD_BIT];
						unit_reg  <= 6'h00;
						cs_n_reg  <= 1'b0;
						state_reg <= H_SETUP;
					end
				end
				H_SETUP: begin
					if (tick)
						state_reg <= H_SHIFT;
				end
				H_SHIFT: begin
					if (tick && !sck_reg) begin
						sck_reg <= 1'b1;
						if (!tx_phase)
							rx_reg <= rx_next;
					end else if (tick) begin
						sck_reg  <= 1'b0;
						unit_reg <= unit_reg + 6'h01;
						tx_reg   <= quad_reg ? (tx_reg << 4) : (tx_reg << 1);
						if (last_unit)
							state_reg <= H_HOLD;
					end
				end
				H_HOLD: begin
					if (tick) begin
						cs_n_reg    <= 1'b1;
						rx_byte_reg <= rx_reg;
						state_reg   <= H_GAP;
						if (!quad_reg && op_reg == OP_QUAD_ENTRY)
							quad_reg <= 1'b1;
						else if (quad_reg && op_reg == OP_QUAD_EXIT)
							quad_reg <= 1'b0;
					end
				end
				H_GAP: begin
					if (gap_done)
						state_reg <= H_IDLE;
				end
				default: state_reg <= H_IDLE;
			endcase
		end
	end

	assign hreadyout  = 1'b1;
	assign hresp      = 1'b0;
	assign hrdata     = hrdata_reg;
	assign link.cs_n  = cs_n_reg;
	assign link.sck   = sck_reg;
	assign link.h_out = quad_reg ? tx_reg[23:20] : {3'h0, tx_reg[23]};
	assign link.h_oe  = !tx_phase ? 4'h0 : (quad_reg ? 4'hF : 4'h1);
endmodule

// ### testbench/fscd_link_assertions.sv
// assertions on the link between the flash setting controller and decoder
// assumes one clk_sys domain and an active low rst_n shared by both ends
module fscd_link_assertions (
	// clock and reset
	input wire logic       clk_sys,
	input wire logic       rst_n,
	// link lines
	input wire logic       cs_n,
	input wire logic       sck,
	input wire logic [3:0] h_oe,
	input wire logic [3:0] d_oe,
	// decoder state
	input wire logic [7:0] status_value,
	input wire logic [7:0] config_value,
	input wire logic       write_enable_latch,
	input wire logic       quad_protocol_mode,
	input wire logic       address_width_flag,
	input wire logic       block_protect_mode,
	input wire logic       deep_power_down
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	logic [3:0]  since_end_reg;
	logic [3:0]  since_end_next;
	wire  [20:0] state_vec = {write_enable_latch, quad_protocol_mode, address_width_flag,
		block_protect_mode, deep_power_down, status_value, config_value};

	// saturates so a long idle spell cannot wrap back into the window
	assign since_end_next = !cs_n ? 4'h0 : (since_end_reg == 4'hf) ? 4'hf : since_end_reg + 4'h1;
	always_ff @(posedge clk_sys) begin
		if (!rst_n)
			since_end_reg <= 4'h0;
		else
			since_end_reg <= since_end_next;
	end

	sequence s_setup;
		!sck [*4];
	endsequence
	sequence s_settled;
		cs_n && (since_end_reg inside {[4'h1:4'h7]});
	endsequence

	property p_sck_idle; cs_n |-> !sck; endproperty
	property p_frame_start; $fell(cs_n) |-> s_setup; endproperty
	property p_act_at_end; $changed(state_vec) |-> s_settled; endproperty
	property p_dev_quiet; cs_n |-> (d_oe == 4'h0); endproperty
	property p_no_fight; (d_oe & h_oe) == 4'h0; endproperty
	property p_spi_reply; !quad_protocol_mode && (d_oe != 4'h0) |-> d_oe == 4'h2; endproperty
	property p_quad_reply; quad_protocol_mode && (d_oe != 4'h0) |-> d_oe == 4'hf; endproperty
	property p_host_lines;
		!cs_n && (h_oe != 4'h0) |-> h_oe == (quad_protocol_mode ? 4'hf : 4'h1);
	endproperty
	property p_pd_silent; deep_power_down |-> (d_oe == 4'h0); endproperty
	property p_latch_bit; status_value[1:0] == {write_enable_latch, 1'h0}; endproperty
	property p_pd_latch; deep_power_down |-> !$rose(write_enable_latch); endproperty

	a_sck_idle: assert property (p_sck_idle) else $error("sck moved outside a frame");
	a_frame_start: assert property (p_frame_start) else $error("sck rose too early");
	a_act_at_end: assert property (p_act_at_end) else $error("state changed off frame end");
	a_dev_quiet: assert property (p_dev_quiet) else $error("decoder drove while idle");
	a_no_fight: assert property (p_no_fight) else $error("both ends drove one line");
	a_spi_reply: assert property (p_spi_reply) else $error("single line reply lines");
	a_quad_reply: assert property (p_quad_reply) else $error("quad reply lines");
	a_host_lines: assert property (p_host_lines) else $error("host drove wrong lines");
	a_pd_silent: assert property (p_pd_silent) else $error("reply during power down");
	a_latch_bit: assert property (p_latch_bit) else $error("latch bit wrong in status");
	a_pd_latch: assert property (p_pd_latch) else $error("latch set in power down");
endmodule

// ### testbench/fscd_tb_top.sv
// bench: controller and decoder joined back to back over one link, plus a
// second decoder fed a short and a whole frame by hand; assumes the core/ files first
module fscd_tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	import fscd_pkg::*;

	logic        clk_sys;
	logic        rst_n;
	logic [31:0] haddr;
	logic        hsel;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [2:0]  hsize;
	logic [31:0] hwdata;
	logic        hreadyout;
	logic        hresp;
	logic [31:0] hrdata;
	fscd_byte_t  status_value;
	fscd_byte_t  config_value;
	logic        write_enable_latch;
	logic        quad_protocol_mode;
	logic        address_width_flag;
	logic        block_protect_mode;
	logic        deep_power_down;
	logic        fault_latch;
	int          bad_count;
	int          tests_run;
	logic        m_latch, m_quad, m_wide, m_prot, m_pd;
	logic [5:0]  m_stat;
	logic [7:0]  m_cfg;
	logic [7:0]  m_rx;
	logic [31:0] last_stat;
	logic [20:0] exp_q[$];
	wire  [20:0] dev_state = {write_enable_latch, quad_protocol_mode, address_width_flag,
		block_protect_mode, deep_power_down, status_value, config_value};

	fscd_link_if link();
	fscd_link_if link2();
	fscd_host fscd_host_i (.clk_sys(clk_sys), .rst_n(rst_n), .haddr(haddr), .hsel(hsel),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .link(link));
	fscd_device fscd_device_i (.clk_sys(clk_sys), .rst_n(rst_n), .link(link),
		.status_value(status_value), .config_value(config_value),
		.write_enable_latch(write_enable_latch), .quad_protocol_mode(quad_protocol_mode),
		.address_width_flag(address_width_flag), .block_protect_mode(block_protect_mode),
		.deep_power_down(deep_power_down));
	fscd_device fscd_device_fault_i (.clk_sys(clk_sys), .rst_n(rst_n), .link(link2),
		.status_value(), .config_value(), .write_enable_latch(fault_latch),
		.quad_protocol_mode(), .address_width_flag(), .block_protect_mode(),
		.deep_power_down());
	fscd_link_assertions fscd_link_assertions_i (.clk_sys(clk_sys), .rst_n(rst_n),
		.cs_n(link.cs_n), .sck(link.sck), .h_oe(link.h_oe), .d_oe(link.d_oe),
		.status_value(status_value), .config_value(config_value),
		.write_enable_latch(write_enable_latch), .quad_protocol_mode(quad_protocol_mode),
		.address_width_flag(address_width_flag), .block_protect_mode(block_protect_mode),
		.deep_power_down(deep_power_down));

	initial begin
		clk_sys = 1'h0;
		forever #2.5 clk_sys = ~clk_sys;
	end

	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic hang;
		bad_count++;
		tally_and_finish();
	endtask

	task automatic chk(input string nm, input logic [20:0] e, input logic [20:0] g);
		tests_run++;
		if (g !== e) begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask

	// entered just after a rising edge, leaves just after one
	task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] wd,
		output logic [31:0] rd);
		int n;
		hsel <= 1'h1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		hsize <= 3'h2;
		n = 0;
		do begin @(posedge clk_sys); n++; end while (hreadyout !== 1'h1 && n < 50);
		hsel <= 1'h0;
		htrans <= 2'h0;
		hwdata <= wd;
		do begin @(posedge clk_sys); n++; end while (hreadyout !== 1'h1 && n < 100);
		rd = hrdata;
		if (n >= 100) hang();
	endtask

	task automatic cmd(input logic [7:0] o, input logic [1:0] cnt, input logic rd,
		input logic [15:0] d);
		logic [31:0] r;
		int n;
		bus(1'h1, 32'h0000_0004, {16'h0000, d}, r);
		bus(1'h1, 32'h0000_0000, {21'h00_0000, rd, cnt, o}, r);
		// busy is already high on the edge that ends the command write; the two-cycle wait is only margin
		repeat (2) @(posedge clk_sys);
		n = 0;
		do begin bus(1'h0, 32'h0000_0008, 32'h0000_0000, r); n++; end
			while (r[0] !== 1'h0 && n < 400);
		if (n >= 400) hang();
		last_stat = r;
	endtask

	task automatic run(input logic [7:0] o, input logic [1:0] cnt, input logic [15:0] d);
		logic rd;
		rd = (o == OP_STATUS_READ) || (o == OP_CONFIG_READ);
		if (rd) m_rx = m_pd ? 8'hff : (o == OP_STATUS_READ) ? {m_stat, m_latch, 1'h0} : m_cfg;
		if (m_pd) m_pd = (o != OP_POWER_RELEASE);
		else if (o == OP_LATCH_SET) m_latch = 1'h1;
		else if (o == OP_LATCH_CLEAR) m_latch = 1'h0;
		else if (o == OP_PROTECT_SEL) m_prot = 1'h1;
		else if (o == OP_QUAD_ENTRY) m_quad = 1'h1;
		else if (o == OP_QUAD_EXIT) m_quad = 1'h0;
		else if (o == OP_WIDE_ENTRY) m_wide = 1'h1;
		else if (o == OP_WIDE_EXIT) m_wide = 1'h0;
		else if (o == OP_POWER_DOWN) m_pd = 1'h1;
		else if (o == OP_SC_WRITE && m_latch && cnt != 2'h0) begin
			m_stat = d[7:2];
			if (cnt >= 2'h2) m_cfg = d[15:8];
			m_latch = 1'h0;
		end
		exp_q.push_back({m_latch, m_quad, m_wide, m_prot, m_pd, m_stat, m_latch, 1'h0, m_cfg});
		cmd(o, cnt, rd, d);
		chk("host status", {12'h000, m_quad, m_rx}, {12'h000, last_stat[1], last_stat[15:8]});
	endtask

	// hand-made frames at a 48 ns link clock, may stop short of a byte
	task automatic raw_frame(input logic [7:0] b, input int bits);
		link2.cs_n = 1'h0;
		link2.h_oe = 4'h1;
		for (int i = 7; i > 7 - bits; i--) begin
			link2.h_out = {3'h0, b[i]};
			#24 link2.sck = 1'h1;
			#24 link2.sck = 1'h0;
		end
		#24 link2.cs_n = 1'h1;
		link2.h_oe = 4'h0;
		repeat (20) @(posedge clk_sys);
	endtask

	always @(posedge link.cs_n) begin
		if (rst_n === 1'h1) begin
			repeat (8) @(posedge clk_sys);
			if (exp_q.size() == 0) hang();
			else chk("device state", exp_q.pop_front(), dev_state);
		end
	end

	initial begin
		logic [31:0] r;
		rst_n = 1'h1;
		{haddr, hwdata, htrans, hsize, hsel, hwrite} = '0;
		{link2.cs_n, link2.sck, link2.h_out, link2.h_oe} = 10'h000;
		// real edges on the asynchronous clears, or link-side flops stay unknown
		#1;
		rst_n = 1'h0;
		link2.cs_n = 1'h1;
		{m_latch, m_quad, m_wide, m_prot, m_pd, m_stat, m_cfg, m_rx} = '0;
		bad_count = 0;
		tests_run = 0;
		void'($urandom(98));
		repeat (8) @(posedge clk_sys);
		rst_n <= 1'h1;
		@(posedge clk_sys);
		chk("reset state", 21'h00_0000, dev_state);
		run(OP_STATUS_READ, 2'h0, 16'h0000);
		run(OP_SC_WRITE, 2'h2, 16'hffff);
		run(OP_LATCH_SET, 2'h0, 16'h0000);
		run(OP_LATCH_CLEAR, 2'h0, 16'h0000);
		run(OP_LATCH_SET, 2'h0, 16'h0000);
		run(OP_SC_WRITE, 2'h2, 16'($urandom));
		run(OP_CONFIG_READ, 2'h0, 16'h0000);
		run(OP_LATCH_SET, 2'h0, 16'h0000);
		run(OP_SC_WRITE, 2'h1, 16'($urandom));
		run(OP_LATCH_SET, 2'h0, 16'h0000);
		run(OP_SC_WRITE, 2'h3, 16'($urandom));
		run(OP_CONFIG_READ, 2'h0, 16'h0000);
		run(OP_STATUS_READ, 2'h0, 16'h0000);
		run(OP_PROTECT_SEL, 2'h0, 16'h0000);
		run(OP_WIDE_ENTRY, 2'h0, 16'h0000);
		run(OP_QUAD_EXIT, 2'h0, 16'h0000);
		run(OP_QUAD_ENTRY, 2'h0, 16'h0000);
		run(OP_QUAD_ENTRY, 2'h0, 16'h0000);
		run(OP_LATCH_SET, 2'h0, 16'h0000);
		run(OP_STATUS_READ, 2'h0, 16'h0000);
		run(OP_SC_WRITE, 2'h2, 16'($urandom));
		run(OP_CONFIG_READ, 2'h0, 16'h0000);
		run(OP_WIDE_EXIT, 2'h0, 16'h0000);
		run(OP_QUAD_EXIT, 2'h0, 16'h0000);
		run(OP_POWER_DOWN, 2'h0, 16'h0000);
		run(OP_LATCH_SET, 2'h0, 16'h0000);
		run(OP_STATUS_READ, 2'h0, 16'h0000);
		run(OP_POWER_RELEASE, 2'h0, 16'h0000);
		run(OP_LATCH_SET, 2'h0, 16'h0000);
		bus(1'h1, 32'h0000_000c, 32'hffff_ffff, r);
		bus(1'h0, 32'h0000_000c, 32'h0000_0000, r);
		chk("unmapped read", 21'h00_0000, r[20:0]);
		chk("bus response", 21'h00_0000, {20'h0_0000, hresp});
		raw_frame(OP_LATCH_SET, 7);
		chk("fault end latch", 21'h00_0000, {20'h0_0000, fault_latch});
		raw_frame(OP_LATCH_SET, 8);
		chk("fault end latch", 21'h00_0001, {20'h0_0000, fault_latch});
		tally_and_finish();
	end
endmodule
